// [bgd_pkg.sv]
// Constants, command codes and carrier types for the gauge data readout.
// Assumes a single 25 MHz clock shared by the command port and gauge logic.
package bgd_pkg;

    // Command codes of the data words
    localparam logic [7:0] CMD_MODE       = 8'h03;
    localparam logic [7:0] CMD_PROBE_RATE = 8'h04;
    localparam logic [7:0] CMD_TTF        = 8'h05;
    localparam logic [7:0] CMD_TTE        = 8'h06;
    localparam logic [7:0] CMD_CAN_SUPPLY = 8'h07;
    localparam logic [7:0] CMD_TEMP       = 8'h08;
    localparam logic [7:0] CMD_VOLTS      = 8'h09;
    localparam logic [7:0] CMD_FLOW_NOW   = 8'h0a;
    localparam logic [7:0] CMD_FLOW_MEAN  = 8'h0b;
    localparam logic [7:0] CMD_MARGIN     = 8'h0c;
    localparam logic [7:0] CMD_PCT_LEARN  = 8'h0d;
    localparam logic [7:0] CMD_PCT_DESIGN = 8'h0e;
    localparam logic [7:0] CMD_LEFT       = 8'h0f;
    localparam logic [7:0] CMD_FULL       = 8'h10;

    // Mode word layout
    localparam int MODE_CAP_BIT = 15;

    // Status error codes
    localparam logic [2:0] ERR_OK          = 3'h0;
    localparam logic [2:0] ERR_NOT_READY   = 3'h1;
    localparam logic [2:0] ERR_UNSUPPORTED = 3'h3;
    localparam logic [2:0] ERR_DENIED      = 3'h4;

    // Word encodings
    localparam logic [15:0] TIME_INVALID = 16'hFFFF;
    localparam logic [15:0] TIME_MAX     = 16'hFFFE;
    localparam logic [15:0] FLAG_TRUE    = 16'h0001;
    localparam logic [15:0] FLAG_FALSE   = 16'h0000;
    localparam logic [15:0] PCT_CAP      = 16'h0064;

    // Error margin values in percent, and the last count of cycles without learning
    localparam logic [6:0] MARGIN_FULL    = 7'h64;
    localparam logic [6:0] MARGIN_LEARNED = 7'h02;
    localparam logic [6:0] MARGIN_CLAMPED = 7'h08;
    localparam logic [6:0] MARGIN_VCORR   = 7'h19;
    localparam logic [6:0] MARGIN_STEP    = 7'h01;
    localparam logic [1:0] CYCLES_LAST    = 2'h3;

    // Arithmetic scales
    localparam logic [23:0] MIN_PER_HOUR = 24'h00_003C;
    localparam logic [23:0] PCT_SCALE    = 24'h00_0064;
    localparam logic [24:0] SUPPLY_SCALE = 25'h000_0168;
    localparam logic [4:0]  DIV_LAST     = 5'h17;
    localparam logic [2:0]  AVG_SHIFT_MAX = 3'h6;
    localparam int          AVG_FRAC     = 6;

    // Timing
    localparam int CLK_KHZ         = 25000;
    localparam int PROBE_SETTLE_MS = 1300;
    localparam int REFRESH_MS      = 20000;
    localparam int PROBE_SETTLE_CYC = PROBE_SETTLE_MS * CLK_KHZ;
    localparam int REFRESH_CYC      = REFRESH_MS * CLK_KHZ;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } bgd_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        ack;
        logic [15:0] data;
    } bgd_rsp_t;

    typedef struct packed {
        logic               sample;
        logic [15:0]        temp_dk;
        logic [15:0]        volt_mv;
        logic signed [15:0] flow_ma;
    } bgd_meas_t;

    typedef struct packed {
        logic        update;
        logic [15:0] left_mah;
        logic [15:0] left_cwh;
        logic [15:0] full_mah;
        logic [15:0] full_cwh;
        logic [15:0] nominal_mah;
        logic [15:0] nominal_cwh;
    } bgd_cap_t;

    typedef struct packed {
        logic full_reset;
        logic learn_done;
        logic learn_clamped;
        logic cycle_inc;
        logic volt_corr;
    } bgd_evt_t;

    typedef enum logic [1:0] {JOB_TTF, JOB_TTE, JOB_RSOC, JOB_ASOC} bgd_job_t;
    typedef enum logic {ST_IDLE, ST_DIV} bgd_fsm_t;

    typedef struct packed {
        bgd_fsm_t           fsm;
        bgd_job_t           job;
        logic [4:0]         step;
        logic [23:0]        quo;
        logic [16:0]        rem;
        logic [15:0]        divisor;
        logic               pass_req;
        logic               pass_clears;
        logic               probe_stale;
        logic [31:0]        settle_cnt;
        logic [31:0]        refresh_cnt;
        logic               cap_mode;
        logic signed [15:0] probe_rate;
        logic [15:0]        ttf;
        logic [15:0]        tte;
        logic               can_supply;
        logic [15:0]        pct_learn;
        logic [15:0]        pct_design;
        logic signed [21:0] avg_acc;
        logic [2:0]         avg_shift;
        logic [6:0]         margin;
        logic [1:0]         cycles_no_learn;
        logic [2:0]         err_code;
        bgd_rsp_t           rsp;
    } bgd_state_t;

endpackage

// [bgd_readout.sv]
// Gauge data readout: word registers reached by command code, probe-rate
// predictions, averaged current and error-margin bookkeeping.
// Assumes the command port and all inputs are synchronous to ref_clk_i.
`timescale 1ns/10ps

module bgd_readout #(
    parameter logic [31:0] SETTLE_CYC  = 32'(bgd_pkg::PROBE_SETTLE_CYC),
    parameter logic [31:0] REFRESH_CYC = 32'(bgd_pkg::REFRESH_CYC)
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire bgd_pkg::bgd_cmd_t cmd_i,
    output bgd_pkg::bgd_rsp_t      rsp_o,
    input  wire bgd_pkg::bgd_meas_t meas_i,
    input  wire bgd_pkg::bgd_cap_t cap_i,
    input  wire bgd_pkg::bgd_evt_t evt_i,
    output logic [2:0]             status_error_code_o,
    output logic                   capacity_mode_o
);
    import bgd_pkg::*;

    bgd_state_t         state_reg;
    bgd_state_t         state_next;
    logic [15:0]        left_sel;
    logic [15:0]        full_sel;
    logic [15:0]        nominal_sel;
    logic [15:0]        rate_mag;
    logic [15:0]        to_fill;
    logic               probe_ready;
    logic [16:0]        shifted;
    logic               div_ok;
    logic signed [22:0] avg_diff;
    logic signed [15:0] flow_mean;

    // Unit selection by the mode word
    always_comb begin
        left_sel    = state_reg.cap_mode ? cap_i.left_cwh : cap_i.left_mah;
        full_sel    = state_reg.cap_mode ? cap_i.full_cwh : cap_i.full_mah;
        nominal_sel = state_reg.cap_mode ? cap_i.nominal_cwh : cap_i.nominal_mah;
        rate_mag    = state_reg.probe_rate[15] ? 16'(-state_reg.probe_rate)
                                               : 16'(state_reg.probe_rate);
        to_fill     = (full_sel > left_sel) ? 16'(full_sel - left_sel) : 16'h0000;
        probe_ready = !state_reg.probe_stale && (state_reg.settle_cnt == 32'h0000_0000);
        shifted     = {state_reg.rem[15:0], state_reg.quo[23]};
        div_ok      = state_reg.divisor != 16'h0000;
        flow_mean   = state_reg.avg_acc[AVG_FRAC +: 16];
        avg_diff    = 23'(($signed({{7{meas_i.flow_ma[15]}}, meas_i.flow_ma}) <<< AVG_FRAC))
                      - 23'(state_reg.avg_acc);
    end

    always_comb begin
        state_next = state_reg;
        state_next.rsp.valid = 1'b0;

        // Periodic refresh of the divided words (times, supply flag, percentages)
        if (state_reg.refresh_cnt == 32'h0000_0000) begin
            state_next.refresh_cnt = REFRESH_CYC - 32'h0000_0001;
            state_next.pass_req    = 1'b1;
        end else begin
            state_next.refresh_cnt = state_reg.refresh_cnt - 32'h0000_0001;
        end
        if (state_reg.settle_cnt != 32'h0000_0000) begin
            state_next.settle_cnt = state_reg.settle_cnt - 32'h0000_0001;
        end
        if (cap_i.update) begin
            state_next.pass_req = 1'b1;
        end

        // Division engine, one quotient bit per cycle
        unique case (state_reg.fsm)
            ST_IDLE: begin
                if (state_reg.pass_req) begin
                    state_next.pass_req    = 1'b0;
                    state_next.pass_clears = state_reg.probe_stale;
                    state_next.fsm         = ST_DIV;
                    state_next.job         = JOB_TTF;
                    state_next.step        = 5'h00;
                    state_next.rem         = 17'h0_0000;
                    state_next.quo         = 24'(to_fill) * MIN_PER_HOUR;
                    state_next.divisor     = rate_mag;
                end
            end
            ST_DIV: begin
                if (shifted >= {1'b0, state_reg.divisor}) begin
                    state_next.rem = 17'(shifted - {1'b0, state_reg.divisor});
                    state_next.quo = {state_reg.quo[22:0], 1'b1};
                end else begin
                    state_next.rem = shifted;
                    state_next.quo = {state_reg.quo[22:0], 1'b0};
                end
                state_next.step = state_reg.step + 5'h01;
                if (state_reg.step == DIV_LAST) begin
                    state_next.step = 5'h00;
                    state_next.rem  = 17'h0_0000;
                    unique case (state_reg.job)
                        JOB_TTF: begin
                            // Meaningful only while a charge rate is probed
                            if (state_next.quo > 24'(TIME_MAX)) begin
                                state_next.ttf = TIME_MAX;
                            end else begin
                                state_next.ttf = state_next.quo[15:0];
                            end
                            if (!div_ok || state_reg.probe_rate[15]) begin
                                state_next.ttf = TIME_INVALID;
                            end
                            state_next.job     = JOB_TTE;
                            state_next.quo     = 24'(left_sel) * MIN_PER_HOUR;
                            state_next.divisor = rate_mag;
                        end
                        JOB_TTE: begin
                            if (state_next.quo > 24'(TIME_MAX)) begin
                                state_next.tte = TIME_MAX;
                            end else begin
                                state_next.tte = state_next.quo[15:0];
                            end
                            if (!div_ok || !state_reg.probe_rate[15]) begin
                                state_next.tte = TIME_INVALID;
                            end
                            // Ten seconds of extra load against charge left
                            state_next.can_supply = !state_reg.probe_rate[15] ||
                                (25'(left_sel) * SUPPLY_SCALE >= 25'(rate_mag));
                            state_next.job     = JOB_RSOC;
                            state_next.quo     = 24'(left_sel) * PCT_SCALE;
                            state_next.divisor = full_sel;
                        end
                        JOB_RSOC: begin
                            if (!div_ok) begin
                                state_next.pct_learn = 16'h0000;
                            end else if (state_next.quo > 24'(PCT_CAP)) begin
                                state_next.pct_learn = PCT_CAP;
                            end else begin
                                state_next.pct_learn = state_next.quo[15:0];
                            end
                            state_next.job     = JOB_ASOC;
                            state_next.quo     = 24'(left_sel) * PCT_SCALE;
                            state_next.divisor = nominal_sel;
                        end
                        JOB_ASOC: begin
                            if (!div_ok) begin
                                state_next.pct_design = 16'h0000;
                            end else if (state_next.quo > 24'(TIME_MAX)) begin
                                state_next.pct_design = TIME_MAX;
                            end else begin
                                state_next.pct_design = state_next.quo[15:0];
                            end
                            state_next.fsm = ST_IDLE;
                            if (state_reg.pass_clears) begin
                                state_next.probe_stale = 1'b0;
                            end
                        end
                    endcase
                end
            end
        endcase

        // Rolling current mean with a widening window during warm-up
        if (meas_i.sample) begin
            state_next.avg_acc = 22'(state_reg.avg_acc + 22'(avg_diff >>> state_reg.avg_shift));
            if (state_reg.avg_shift != AVG_SHIFT_MAX) begin
                state_next.avg_shift = state_reg.avg_shift + 3'h1;
            end
        end

        // Error margin bookkeeping, strongest event first
        if (evt_i.full_reset) begin
            state_next.margin          = MARGIN_FULL;
            state_next.cycles_no_learn = 2'h0;
        end else if (evt_i.volt_corr) begin
            state_next.margin = MARGIN_VCORR;
        end else if (evt_i.learn_done) begin
            state_next.cycles_no_learn = 2'h0;
            if (!evt_i.learn_clamped) begin
                state_next.margin = MARGIN_LEARNED;
            end else if (state_reg.margin >= MARGIN_CLAMPED) begin
                state_next.margin = MARGIN_CLAMPED;
            end
        end else if (evt_i.cycle_inc) begin
            state_next.cycles_no_learn = state_reg.cycles_no_learn + 2'h1;
            if (state_reg.cycles_no_learn == CYCLES_LAST &&
                state_reg.margin < MARGIN_FULL) begin
                state_next.margin = state_reg.margin + MARGIN_STEP;
            end
        end

        // Command port
        if (cmd_i.valid) begin
            state_next.rsp.valid = 1'b1;
            state_next.rsp.ack   = 1'b1;
            state_next.rsp.data  = 16'h0000;
            state_next.err_code  = ERR_OK;
            if (cmd_i.write) begin
                unique case (cmd_i.code)
                    CMD_MODE: begin
                        state_next.cap_mode = cmd_i.wdata[MODE_CAP_BIT];
                        state_next.pass_req = 1'b1;
                    end
                    CMD_PROBE_RATE: begin
                        state_next.probe_rate  = $signed(cmd_i.wdata);
                        state_next.probe_stale = 1'b1;
                        state_next.pass_clears = 1'b0;
                        state_next.pass_req    = 1'b1;
                        state_next.settle_cnt  = SETTLE_CYC;
                    end
                    default: begin
                        state_next.rsp.ack  = 1'b0;
                        state_next.err_code = ERR_DENIED;
                    end
                endcase
            end else begin
                unique case (cmd_i.code)
                    CMD_MODE:       state_next.rsp.data = {state_reg.cap_mode, 15'h0000};
                    CMD_PROBE_RATE: state_next.rsp.data = state_reg.probe_rate;
                    CMD_TTF:        state_next.rsp.data = state_reg.ttf;
                    CMD_TTE:        state_next.rsp.data = state_reg.tte;
                    CMD_CAN_SUPPLY: state_next.rsp.data = state_reg.can_supply ? FLAG_TRUE
                                                                               : FLAG_FALSE;
                    CMD_TEMP:       state_next.rsp.data = meas_i.temp_dk;
                    CMD_VOLTS:      state_next.rsp.data = meas_i.volt_mv;
                    CMD_FLOW_NOW:   state_next.rsp.data = meas_i.flow_ma;
                    CMD_FLOW_MEAN:  state_next.rsp.data = flow_mean;
                    CMD_MARGIN:     state_next.rsp.data = {9'h000, state_reg.margin};
                    CMD_PCT_LEARN:  state_next.rsp.data = state_reg.pct_learn;
                    CMD_PCT_DESIGN: state_next.rsp.data = state_reg.pct_design;
                    CMD_LEFT:       state_next.rsp.data = left_sel;
                    CMD_FULL:       state_next.rsp.data = full_sel;
                    default: begin
                        state_next.rsp.ack  = 1'b0;
                        state_next.err_code = ERR_UNSUPPORTED;
                    end
                endcase
                if ((cmd_i.code == CMD_TTF || cmd_i.code == CMD_TTE ||
                     cmd_i.code == CMD_CAN_SUPPLY) && !probe_ready) begin
                    state_next.rsp.ack  = 1'b0;
                    state_next.rsp.data = 16'h0000;
                    state_next.err_code = ERR_NOT_READY;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_reg             <= '0;
            state_reg.fsm         <= ST_IDLE;
            state_reg.job         <= JOB_TTF;
            state_reg.pass_req    <= 1'b1;
            state_reg.refresh_cnt <= REFRESH_CYC - 32'h0000_0001;
            state_reg.ttf         <= TIME_INVALID;
            state_reg.tte         <= TIME_INVALID;
            state_reg.can_supply  <= 1'b1;
            state_reg.margin      <= MARGIN_FULL;
            state_reg.err_code    <= ERR_OK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rsp_o               = state_reg.rsp;
    assign status_error_code_o = state_reg.err_code;
    assign capacity_mode_o     = state_reg.cap_mode;

endmodule

// [bgd_readout_checker.sv]
// Port checker for the gauge data readout.
// Assumes it is bound to bgd_readout and sees only that module's ports.
`timescale 1ns/10ps
module bgd_readout_checker (
    input wire logic               ref_clk_i,
    input wire logic               reset_n_i,
    input wire bgd_pkg::bgd_cmd_t  cmd_i,
    input wire bgd_pkg::bgd_rsp_t  rsp_o,
    input wire bgd_pkg::bgd_meas_t meas_i,
    input wire bgd_pkg::bgd_cap_t  cap_i,
    input wire bgd_pkg::bgd_evt_t  evt_i,
    input wire logic [2:0]         status_error_code_o,
    input wire logic               capacity_mode_o
);
    import bgd_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic rd_cmd = cmd_i.valid && !cmd_i.write;
    a_answer_next: assert property (cmd_i.valid |=> rsp_o.valid)
        else $error("no answer after command");
    a_no_stray: assert property (!cmd_i.valid |=> !rsp_o.valid)
        else $error("answer without command");
    a_volts_word: assert property (rd_cmd && cmd_i.code == CMD_VOLTS
        |=> rsp_o.ack && rsp_o.data == $past(meas_i.volt_mv)) else $error("voltage word");
    a_temp_word: assert property (rd_cmd && cmd_i.code == CMD_TEMP
        |=> rsp_o.ack && rsp_o.data == $past(meas_i.temp_dk)) else $error("temperature word");
    a_flow_word: assert property (rd_cmd && cmd_i.code == CMD_FLOW_NOW
        |=> rsp_o.ack && rsp_o.data == $past(meas_i.flow_ma)) else $error("current word");
    a_probe_early: assert property (cmd_i.valid && cmd_i.write &&
        cmd_i.code == CMD_PROBE_RATE ##2 rd_cmd && cmd_i.code == CMD_TTF
        |=> !rsp_o.ack && status_error_code_o == ERR_NOT_READY) else $error("early probe read");
    a_left_units: assert property (rd_cmd && cmd_i.code == CMD_LEFT |=> rsp_o.data ==
        (capacity_mode_o ? $past(cap_i.left_cwh) : $past(cap_i.left_mah))) else $error("left unit");
    a_full_units: assert property (rd_cmd && cmd_i.code == CMD_FULL |=> rsp_o.data ==
        (capacity_mode_o ? $past(cap_i.full_cwh) : $past(cap_i.full_mah))) else $error("full unit");
    a_margin_span: assert property (rd_cmd && cmd_i.code == CMD_MARGIN
        |=> rsp_o.ack && rsp_o.data inside {[2:100]}) else $error("margin span");
    a_mode_default: assert property ($rose(reset_n_i) |-> !capacity_mode_o)
        else $error("mode after reset");
endmodule
bind bgd_readout bgd_readout_checker u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .cmd_i(cmd_i), .rsp_o(rsp_o), .meas_i(meas_i), .cap_i(cap_i), .evt_i(evt_i),
    .status_error_code_o(status_error_code_o), .capacity_mode_o(capacity_mode_o));

// [bgd_host.sv]
// Word-command host model for the gauge readout command port.
// Assumes the answer arrives on the cycle after the command strobe.
`timescale 1ns/10ps
module bgd_host (
    input  wire logic              ref_clk_i,
    output bgd_pkg::bgd_cmd_t      cmd_o,
    input  wire bgd_pkg::bgd_rsp_t rsp_i,
    output logic                   ok_o,
    output logic [15:0]            data_o,
    output logic                   to_o
);
    import bgd_pkg::*;
    initial cmd_o = '0;
    initial to_o = 1'b0;
    // One word per command, rate sent as signed word
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        int n;
        @(negedge ref_clk_i);
        cmd_o = {1'b1, w, c, d};
        for (n = 0; n < 4 && rsp_i.valid !== 1'b1; n++) begin
            @(negedge ref_clk_i);
            cmd_o.valid = 1'b0;
            cmd_o.wdata = ~d;
        end
        ok_o = rsp_i.ack;
        data_o = rsp_i.data;
        to_o = (rsp_i.valid !== 1'b1);
    endtask
endmodule

// [battery_gauge_data_readout_test.sv]
// Self-checking bench for the gauge data readout.
// Assumes the package, design, host model and bound checker compile first.
`timescale 1ns/10ps
module battery_gauge_data_readout_test;
    import bgd_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    bgd_cmd_t    cmd;
    bgd_rsp_t    rsp;
    bgd_meas_t   meas = '0;
    bgd_cap_t    cap = '0;
    bgd_evt_t    evt = '0;
    bgd_evt_t    seq [12] = '{5'h01, 5'h08, 5'h0C, 5'h02, 5'h02, 5'h02, 5'h02, 5'h01,
                              5'h0C, 5'h02, 5'h10, 5'h02};
    logic [2:0]  err;
    logic        mode, ok, to;
    logic [15:0] hd;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 47759;
    int mg = 100, cy = 0, acc = 0, sh = 0, x, i;
    always #20 ref_clk_i = ~ref_clk_i;
    bgd_readout #(.SETTLE_CYC(32'h0000_00C8), .REFRESH_CYC(32'h0000_03E8)) u_dut (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd), .rsp_o(rsp),
        .meas_i(meas), .cap_i(cap), .evt_i(evt), .status_error_code_o(err),
        .capacity_mode_o(mode));
    bgd_host u_host (.ref_clk_i(ref_clk_i), .cmd_o(cmd), .rsp_i(rsp), .ok_o(ok),
        .data_o(hd), .to_o(to));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge to) begin
        bad_count++;
        print_verdict();
    end
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic rd(logic [7:0] c, logic [15:0] e);
        u_host.xfer(1'b0, c, 16'h0000);
        #1;
        cmp($sformatf("ack %h", c), 16'h0001, {15'h0000, ok});
        cmp($sformatf("word %h", c), e, hd);
    endtask
    task automatic nak(logic w, logic [7:0] c, logic [15:0] d, logic [2:0] e);
        u_host.xfer(w, c, d);
        #1;
        cmp("refused ack", 16'h0000, {15'h0000, ok});
        cmp("error code", {13'h0000, e}, {13'h0000, err});
    endtask
    task automatic pchk(int r);
        int l, t;
        l = cap.left_mah;
        t = cap.full_mah;
        t = r > 0 ? ((t > l ? t - l : 0) * 60) / r : -1;
        rd(CMD_TTF, 16'(t < 0 ? 65535 : (t > 65534 ? 65534 : t)));
        t = r < 0 ? (l * 60) / -r : -1;
        rd(CMD_TTE, 16'(t < 0 ? 65535 : (t > 65534 ? 65534 : t)));
        rd(CMD_CAN_SUPPLY, (r >= 0 || l * 360 >= -r) ? FLAG_TRUE : FLAG_FALSE);
    endtask
    initial begin
        repeat (3) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        rd(CMD_MARGIN, 16'h0064);
        rd(CMD_MODE, 16'h0000);
        for (i = 0; i < 4; i++) begin
            x = $random(seed) % 8000;
            @(negedge ref_clk_i);
            meas = {1'b1, 16'($random(seed)), 16'($unsigned($random(seed)) % 20001), 16'(x)};
            @(negedge ref_clk_i);
            meas.sample = 1'b0;
            acc = acc + ((x * 64 - acc) >>> sh);
            sh = sh < 6 ? sh + 1 : 6;
            rd(CMD_TEMP, meas.temp_dk);
            rd(CMD_VOLTS, meas.volt_mv);
            rd(CMD_FLOW_NOW, meas.flow_ma);
            rd(CMD_FLOW_MEAN, 16'(acc >>> 6));
        end
        $display("test measurements done");
        foreach (seq[k]) begin
            @(negedge ref_clk_i);
            evt = seq[k];
            @(negedge ref_clk_i);
            evt = '0;
            if (seq[k].cycle_inc) cy++;
            if (seq[k].full_reset || seq[k].learn_done) cy = 0;
            if (seq[k].full_reset) mg = 100;
            if (seq[k].volt_corr) mg = 25;
            if (seq[k].learn_done) mg = seq[k].learn_clamped ? (mg < 8 ? mg : 8) : 2;
            if (seq[k].cycle_inc && cy % 4 == 0 && mg < 100) mg++;
            rd(CMD_MARGIN, 16'(mg));
        end
        $display("test margin done");
        @(negedge ref_clk_i);
        cap = {1'b1, 16'h0708, 16'($random(seed)), 16'h07D0, 16'($random(seed)),
               16'h05DC, 16'h0000};
        @(negedge ref_clk_i);
        cap.update = 1'b0;
        repeat (150) @(negedge ref_clk_i);
        rd(CMD_PCT_LEARN, 16'h005A);
        rd(CMD_PCT_DESIGN, 16'h0078);
        rd(CMD_LEFT, cap.left_mah);
        rd(CMD_FULL, cap.full_mah);
        u_host.xfer(1'b1, CMD_MODE, 16'h8000);
        rd(CMD_LEFT, cap.left_cwh);
        rd(CMD_FULL, cap.full_cwh);
        rd(CMD_MODE, 16'h8000);
        cmp("mode pin", 16'h0001, {15'h0000, mode});
        u_host.xfer(1'b1, CMD_MODE, 16'h0000);
        $display("test capacity done");
        for (i = 0; i < 3; i++) begin
            x = i == 0 ? 500 : (i == 1 ? 0 : -30000);
            u_host.xfer(1'b1, CMD_PROBE_RATE, 16'(x));
            nak(1'b0, CMD_TTF, 16'h0000, ERR_NOT_READY);
            repeat (400) @(negedge ref_clk_i);
            pchk(x);
        end
        cap.left_mah = 16'h0014;
        repeat (1200) @(negedge ref_clk_i);
        pchk(x);
        nak(1'b0, 8'h20, 16'h0000, ERR_UNSUPPORTED);
        nak(1'b1, CMD_VOLTS, 16'h1234, ERR_DENIED);
        $display("test probe and refusals done");
        print_verdict();
    end
endmodule
